// ===== src/ssb_top.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1: Status register reads zero outside the three flag bits.
// R2: Writes to the status register change nothing.
// R3: Receive-full flag, bit 7, sets when a received byte enters the buffer.
// R4: Receive-full clears on data read after a status read saw it set.
// R5: Transmit-empty flag, bit 5, is one while the transmit buffer has room.
// R6: Data write after status read seeing transmit-empty loads buffer, clears flag.
// R7: A data write without that armed status read is discarded.
// R8: Transmit interrupt follows transmit-empty flag and transmit interrupt enable.
// R9: Transmit-empty sets when a byte moves from buffer into shifter.
// R10: On an idle interface a written byte reaches the shifter within two cycles.
// R11: A waiting byte moves into the shifter when a transfer finishes.
// R12: With no byte waiting, transmit-empty stays set and nothing moves.
// R13: Mode-fault flag, bit 4, sets when master sees slave select low.
// R14: Mode-fault detection only with master, fault enable on, select output off.
// R15: Mode-fault clears on a first control register write after status read saw it set.
// R16: Data register reads return the receive buffer.
// R17: In master mode an accepted transmit byte starts a transfer by itself.
// R18: Software should write data only while transmit-empty shows room.
// R19: Software must read a received byte before the next transfer ends.
// R20: On overrun the old byte is kept and the new byte dropped.
// R21: An overrun raises no flag or indication.
// R22: Receive/fault interrupt follows either flag and its interrupt enable.
// R23: Clears are armed by a status read; wrong-register accesses disarm.
// R24: Interrupt requests stay while flag and enable are set, drop on clear.
module ssb_top import ssb_pkg::*; #(
    parameter int SCK_HALF = SCK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic tx_irq_o,
    output logic rx_irq_o
);
    ssb_shift_if sif ();

    logic [BITS-1:0] ctrl1_r, ctrl2_r, tx_buf_r, rx_buf_r;
    logic rx_full_r, tx_empty_r, mf_r;
    logic rx_arm_r, tx_arm_r, mf_arm_r;
    logic load_r, ss_meta_r, ss_sync_r;
    logic [DATA_W-1:0] prdata_r;
    logic pready_r, pslverr_r, ss_n_r, ss_oe_r, tx_irq_r, rx_irq_r;
    logic data_out;

    // bus phase decode
    logic setup, access, wr_acc, rd_acc;
    logic hit_c1, hit_c2, hit_fl, hit_buf, mapped;
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_r;
    assign wr_acc = access && pwrite_i;
    assign rd_acc = access && !pwrite_i;
    assign hit_c1 = paddr_i == OFF_CTRL1;
    assign hit_c2 = paddr_i == OFF_CTRL2;
    assign hit_fl = paddr_i == OFF_FLAGS;
    assign hit_buf = paddr_i == OFF_BUFFER;
    assign mapped = hit_c1 || hit_c2 || hit_fl || hit_buf;

    // control fields
    logic msel, mf_en, sel_oe, tx_ie, rf_ie;
    assign msel = ctrl1_r[BIT_MSEL];
    assign sel_oe = ctrl1_r[BIT_SEL_OE];
    assign tx_ie = ctrl1_r[BIT_TX_IE];
    assign rf_ie = ctrl1_r[BIT_RF_IE];
    assign mf_en = ctrl2_r[BIT_MF_EN];

    // status image, only three bits have storage
    logic [BITS-1:0] flags;
    always_comb begin
        flags = '0; // R1
        flags[BIT_RXF] = rx_full_r;
        flags[BIT_TXE] = tx_empty_r;
        flags[BIT_MFLT] = mf_r;
    end

    // read mux
    logic [BITS-1:0] rdata;
    always_comb begin
        rdata = '0;
        if (hit_c1) begin
            rdata = ctrl1_r;
        end else if (hit_c2) begin
            rdata = ctrl2_r;
        end else if (hit_fl) begin
            rdata = flags;
        end else if (hit_buf) begin
            rdata = rx_buf_r; // R16
        end
    end

    // apb answer: data and ready set up for the access phase
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= pwrite_i ? '0 : DATA_W'(rdata);
            end
        end
    end

    // control register writes; status writes fall through untouched
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl1_r <= CTRL1_RST;
            ctrl2_r <= CTRL2_RST;
        end else if (wr_acc && hit_c1) begin
            ctrl1_r <= pwdata_i[BITS-1:0] & CTRL1_MASK;
        end else if (wr_acc && hit_c2) begin
            ctrl2_r <= pwdata_i[BITS-1:0] & CTRL2_MASK; // R2
        end
    end

    // two-step clear events, armed by the status value actually returned
    logic [BITS-1:0] seen;
    logic rd_fl, ctl_acc, rx_clr, tx_take, mf_clr, mf_cond, move;
    assign seen = prdata_r[BITS-1:0];
    assign rd_fl = rd_acc && hit_fl;
    assign ctl_acc = access && (hit_c1 || hit_c2);
    assign rx_clr = rd_acc && hit_buf && rx_arm_r; // R4
    assign tx_take = wr_acc && hit_buf && tx_arm_r; // R6 R7
    assign mf_clr = wr_acc && hit_c1 && mf_arm_r; // R15

    // arm flags, dropped by a foreign register access
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_arm_r <= 1'b0;
            tx_arm_r <= 1'b0;
            mf_arm_r <= 1'b0;
        end else begin
            if (rd_fl) begin
                rx_arm_r <= seen[BIT_RXF]; // R23
            end else if (rx_clr || ctl_acc) begin
                rx_arm_r <= 1'b0;
            end
            if (rd_fl) begin
                tx_arm_r <= seen[BIT_TXE]; // R23
            end else if (tx_take || ctl_acc) begin
                tx_arm_r <= 1'b0;
            end
            if (rd_fl) begin
                mf_arm_r <= seen[BIT_MFLT]; // R23
            end else if (access && (hit_buf || hit_c2 || hit_c1)) begin
                mf_arm_r <= 1'b0;
            end
        end
    end

    // receive buffer: new byte kept only if the old one is gone
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_full_r <= 1'b0;
            rx_buf_r <= '0;
        end else begin
            if (sif.done) begin
                rx_full_r <= 1'b1; // R3
            end else if (rx_clr) begin
                rx_full_r <= 1'b0; // R4
            end
            if (sif.done && (!rx_full_r || rx_clr)) begin
                rx_buf_r <= sif.rx_data; // R20 R21
            end
        end
    end

    // transmit buffer and its move into the shifter
    assign move = !tx_empty_r && !sif.holding && !load_r; // R11 R12
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_empty_r <= TXE_RST;
            tx_buf_r <= '0;
            load_r <= 1'b0;
        end else begin
            load_r <= move; // R10
            if (move) begin
                tx_empty_r <= 1'b1; // R9 R5
            end else if (tx_take) begin
                tx_empty_r <= 1'b0; // R6
            end
            if (tx_take) begin
                tx_buf_r <= pwdata_i[BITS-1:0]; // R6
            end
        end
    end

    // slave select sampling and mode-fault detection
    assign mf_cond = msel && mf_en && !sel_oe && !ss_sync_r; // R13 R14
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ss_meta_r <= 1'b1;
            ss_sync_r <= 1'b1;
            mf_r <= 1'b0;
        end else begin
            ss_meta_r <= ss_n_i;
            ss_sync_r <= ss_meta_r;
            if (mf_cond) begin
                mf_r <= 1'b1; // R13
            end else if (mf_clr) begin
                mf_r <= 1'b0; // R15
            end
        end
    end

    // automatic select output and interrupt requests
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ss_n_r <= 1'b1;
            ss_oe_r <= 1'b0;
            tx_irq_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end else begin
            ss_n_r <= !sif.active;
            ss_oe_r <= msel && mf_en && sel_oe;
            tx_irq_r <= tx_empty_r && tx_ie; // R8 R24
            rx_irq_r <= (rx_full_r || mf_r) && rf_ie; // R22 R24
        end
    end

    assign sif.load = load_r;
    assign sif.load_data = tx_buf_r;
    assign sif.master = msel;
    assign sif.sel_n = ss_sync_r;

    ssb_shifter #(
        .HALF_CYC(SCK_HALF)
    ) u_shifter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .sif(sif),
        .sck_i(sck_i),
        .mosi_i(mosi_i),
        .miso_i(miso_i),
        .sck_o(sck_o),
        .sck_oe_o(sck_oe_o),
        .data_o(data_out),
        .mosi_oe_o(mosi_oe_o),
        .miso_oe_o(miso_oe_o)
    );

    assign mosi_o = data_out;
    assign miso_o = data_out;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign ss_n_o = ss_n_r;
    assign ss_n_oe_o = ss_oe_r;
    assign tx_irq_o = tx_irq_r;
    assign rx_irq_o = rx_irq_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_hand_over;
        (sif.load && tx_empty_r) ##1 sif.holding;
    endsequence

    flags_zero_a: assert property (rd_fl |-> (prdata_o[BITS-1:0] & ~FLAG_MASK) == '0) // R1
        else $error("unused status bits not zero");
    stat_write_a: assert property (wr_acc && hit_fl && !sif.done && !move && !mf_cond // R2
        |=> flags == $past(flags))
        else $error("status write changed a flag");
    rx_set_a: assert property (sif.done |=> rx_full_r) // R3
        else $error("receive-full not set after transfer");
    rx_hold_a: assert property (rx_full_r && !rx_arm_r && !sif.done |=> rx_full_r) // R4
        else $error("receive-full cleared without armed read");
    tx_drop_a: assert property (wr_acc && hit_buf && !tx_arm_r |=> $stable(tx_buf_r)) // R7
        else $error("unarmed data write reached transmit buffer");
    tx_idle_a: assert property (tx_take && !sif.holding && !load_r |-> ##[1:2] tx_empty_r) // R10
        else $error("idle write not handed to shifter in time");
    tx_move_a: assert property (move |=> s_hand_over) // R11
        else $error("waiting byte not moved into shifter");
    tx_still_a: assert property (tx_empty_r && !tx_take |=> tx_empty_r && !sif.load) // R12
        else $error("transmit-empty dropped with no byte");
    mf_gate_a: assert property (!(msel && mf_en && !sel_oe) && !mf_r |=> !mf_r) // R14
        else $error("mode fault set outside its configuration");
    mf_clear_a: assert property (mf_clr && !mf_cond |=> !mf_r) // R15
        else $error("mode fault not cleared by armed control write");
    rx_keep_a: assert property (sif.done && rx_full_r && !rx_clr |=> $stable(rx_buf_r)) // R20
        else $error("overrun replaced unread byte");
    tx_irq_a: assert property (tx_empty_r && tx_ie |=> tx_irq_o) // R8
        else $error("transmit interrupt missing");
    rx_irq_a: assert property (!rx_full_r && !mf_r |=> !rx_irq_o) // R24
        else $error("receive or fault interrupt without flag");
endmodule // ssb_top

// ===== common/ssb_pkg.sv
package ssb_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BITS = 8;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_BUFFER = 8'h0c;
    // serial_port_flags field positions
    localparam int BIT_RXF = 7;
    localparam int BIT_TXE = 5;
    localparam int BIT_MFLT = 4;
    localparam logic [BITS-1:0] FLAG_MASK = 8'hb0;
    // first_control_register field positions
    localparam int BIT_RF_IE = 7;
    localparam int BIT_TX_IE = 5;
    localparam int BIT_MSEL = 4;
    localparam int BIT_SEL_OE = 1;
    localparam logic [BITS-1:0] CTRL1_MASK = 8'hb2;
    // second control register field positions
    localparam int BIT_MF_EN = 4;
    localparam logic [BITS-1:0] CTRL2_MASK = 8'h10;
    // reset values
    localparam logic [BITS-1:0] CTRL1_RST = 8'h00;
    localparam logic [BITS-1:0] CTRL2_RST = 8'h00;
    localparam logic TXE_RST = 1'b1;
    // master serial clock timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_PERIOD_NS = 800;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ===== common/ssb_shift_if.sv
`timescale 1ns/1ps
interface ssb_shift_if;
    import ssb_pkg::*;
    logic load;
    logic [BITS-1:0] load_data;
    logic master;
    logic sel_n;
    logic holding;
    logic active;
    logic done;
    logic [BITS-1:0] rx_data;
    modport core (
        output load, load_data, master, sel_n,
        input holding, active, done, rx_data
    );
    modport engine (
        input load, load_data, master, sel_n,
        output holding, active, done, rx_data
    );
endinterface

// ===== src/ssb_shifter.sv
`timescale 1ns/1ps
module ssb_shifter import ssb_pkg::*; #(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    ssb_shift_if.engine sif,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic data_o,
    output logic mosi_oe_o,
    output logic miso_oe_o
);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(HALF_CYC - 1);
    localparam logic [3:0] CNT_LAST = 4'(BITS);

    if (HALF_CYC < 1) begin : g_bad_half
        $error("HALF_CYC must be at least one");
    end

    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic sck_q_r, sck_r, active_r, holding_r, done_r, rbit_r, m_oe_r, s_oe_r;
    logic [DW-1:0] div_r;
    logic [3:0] cnt_r;
    logic [BITS-1:0] sreg_r, rx_r;
    logic tick, rise, fall, last;

    // two-flop sampling of link pins: sck, mosi, miso
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_r <= '0;
            sck_q_r <= 1'b0;
        end else begin
            meta_r <= {sck_i, mosi_i, miso_i};
            sync_r <= meta_r;
            sck_q_r <= sync_r[2];
        end
    end

    // edges from own divider as master, from sampled link clock as slave
    assign tick = sif.master && active_r && div_r == DIV_LAST;
    assign rise = active_r && (sif.master ? tick && !sck_r : sync_r[2] && !sck_q_r);
    assign fall = active_r && (sif.master ? tick && sck_r : !sync_r[2] && sck_q_r);
    assign last = fall && cnt_r == CNT_LAST;

    // half-period divider and master clock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_r <= '0;
            sck_r <= 1'b0;
        end else begin
            div_r <= (!active_r || tick) ? '0 : div_r + 1'b1;
            if (!sif.master) begin
                sck_r <= 1'b0;
            end else if (tick) begin
                sck_r <= !sck_r;
            end
        end
    end

    // transfer window: master starts on a held byte, slave follows select
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            active_r <= 1'b0;
        end else if (!sif.master) begin
            active_r <= !sif.sel_n;
        end else if (last) begin
            active_r <= 1'b0;
        end else if (holding_r) begin
            active_r <= 1'b1; // R17
        end
    end

    // bit counter and sampled bit
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            rbit_r <= 1'b0;
        end else begin
            if (!active_r || last) begin
                cnt_r <= '0;
            end else if (rise) begin
                cnt_r <= cnt_r + 1'b1;
            end
            if (rise) begin
                rbit_r <= sif.master ? sync_r[0] : sync_r[1];
            end
        end
    end

    // shift register, held-byte flag and completed byte
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sreg_r <= '0;
            holding_r <= 1'b0;
            done_r <= 1'b0;
            rx_r <= '0;
        end else begin
            done_r <= last;
            if (sif.load) begin
                sreg_r <= sif.load_data;
                holding_r <= 1'b1;
            end else if (last) begin
                holding_r <= 1'b0;
            end else if (fall) begin
                sreg_r <= {sreg_r[BITS-2:0], rbit_r};
            end
            if (last) begin
                rx_r <= {sreg_r[BITS-2:0], rbit_r};
            end
        end
    end

    // pin drivers enabled by role
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            m_oe_r <= 1'b0;
            s_oe_r <= 1'b0;
        end else begin
            m_oe_r <= sif.master;
            s_oe_r <= !sif.master && !sif.sel_n;
        end
    end

    assign sif.holding = holding_r;
    assign sif.active = active_r;
    assign sif.done = done_r;
    assign sif.rx_data = rx_r;
    assign sck_o = sck_r;
    assign sck_oe_o = m_oe_r;
    assign mosi_oe_o = m_oe_r;
    assign miso_oe_o = s_oe_r;
    assign data_o = sreg_r[BITS-1];

    start_a: assert property (@(posedge clk_i) disable iff (reset_i) // R17
        sif.load && sif.master |-> ##[1:2] active_r)
        else $error("master load did not start a transfer");
endmodule // ssb_shifter

// ===== sim/ssb_peer.sv
`timescale 1ns/1ps
// serial peer in mode 0: shifts out what it received in the frame before
module ssb_peer #(
    parameter logic [7:0] INIT = 8'h3c
) (
    input wire logic sck_i,
    input wire logic sel_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [7:0] last_o,
    output logic [7:0] frames_o
);
    logic [7:0] sr;
    logic in_bit;
    logic [2:0] cnt;
    initial begin
        sr = INIT;
        miso_o = 1'b0;
        last_o = 8'h00;
        frames_o = 8'h00;
        cnt = 3'd0;
        in_bit = 1'b0;
    end
    // msb goes out on select, before the first rising edge
    always @(negedge sel_n_i) begin
        miso_o <= sr[7];
        cnt <= 3'd0;
    end
    // released line flips to the inverse of its last bit
    always @(posedge sel_n_i) begin
        miso_o <= ~miso_o;
    end
    // sample on the rising edge
    always @(posedge sck_i) begin
        if (!sel_n_i) begin
            in_bit <= mosi_i;
        end
    end
    // shift on the falling edge and count whole bytes
    always @(negedge sck_i) begin
        if (!sel_n_i) begin
            sr <= {sr[6:0], in_bit};
            miso_o <= sr[6];
            cnt <= cnt + 3'd1;
            if (cnt == 3'd7) begin
                frames_o <= frames_o + 8'd1;
                last_o <= {sr[6:0], in_bit};
            end
        end
    end
endmodule // ssb_peer

// ===== sim/tb_spi_status_data_buffering.sv
`timescale 1ns/1ps
module tb_spi_status_data_buffering;
    import ssb_pkg::*;
    logic clk_i, reset_i, psel_i, penable_i, pwrite_i, err;
    logic [ADDR_W-1:0] paddr_i;
    logic [DATA_W-1:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, ss_n_o, ss_n_oe_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o;
    logic miso_o, miso_oe_o, tx_irq_o, rx_irq_o, ss_drv, ss_pin, miso_wire, peer_miso;
    logic [7:0] peer_last, peer_frames;
    logic sck_drv, mosi_drv;
    localparam logic [7:0] SL_BYTE = 8'hc3;
    logic [7:0] c1_tab [3] = '{8'h80, 8'h90, 8'h90};
    logic [7:0] c2_tab [3] = '{8'h10, 8'h00, 8'h10};
    logic [7:0] flt_tab [3] = '{8'h00, 8'h00, 8'h10};
    int bad_count, n_compared, i;

    // select and miso levels from whichever side is enabled; the bench drives select when the DUT does not
    assign ss_pin = ss_n_oe_o ? ss_n_o : ss_drv;
    assign miso_wire = miso_oe_o ? miso_o : peer_miso;

    ssb_top #(.SCK_HALF(4)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ss_n_i(ss_pin), .ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe_o),
        .sck_i(sck_drv), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .mosi_i(mosi_drv), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_i(miso_wire), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o)
    );

    ssb_peer #(.INIT(8'h3c)) peer (
        .sck_i(sck_o), .sel_n_i(ss_pin), .mosi_i(mosi_o), .miso_o(peer_miso),
        .last_o(peer_last), .frames_o(peer_frames)
    );

    // 100 ns bus clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus transfer, entered just after a rising edge; holds until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            check("pready", 0, 1);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end

    initial begin
        bad_count = 0;
        n_compared = 0;
        reset_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        ss_drv = 1'b1;
        sck_drv = 1'b0;
        mosi_drv = 1'b0;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset values, read-only flags, unmapped place
        rdchk(OFF_FLAGS, 32'h20, "flags reset");
        rdchk(OFF_CTRL1, 32'h00, "ctrl1 reset");
        rdchk(OFF_CTRL2, 32'h00, "ctrl2 reset");
        wr(OFF_FLAGS, 32'hff);
        rdchk(OFF_FLAGS, 32'h20, "flags write");
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", err, 1);
        check("unmapped data", rd, 0);
        $display("test registers done");
        // master with automatic select; control accesses disarm the write
        wr(OFF_CTRL2, 32'h10);
        wr(OFF_CTRL1, 32'h12);
        wr(OFF_BUFFER, 32'ha5);
        repeat (80) @(posedge clk_i);
        check("no transfer", peer_frames, 0);
        rdchk(OFF_FLAGS, 32'h20, "flags after drop");
        $display("test discarded write done");
        // armed write, second byte queued, overrun on the second
        wr(OFF_BUFFER, 32'h96);
        rdchk(OFF_FLAGS, 32'h20, "flags idle move");
        wr(OFF_BUFFER, 32'h69);
        rdchk(OFF_FLAGS, 32'h00, "flags queued");
        i = 0;
        do begin
            apb(1'b0, OFF_FLAGS, 32'h0);
            i++;
        end while (rd[7] !== 1'b1 && i < 100);
        check("flags first done", rd, 32'ha0);
        check("peer first byte", peer_last, 8'h96);
        i = 0;
        while ((peer_frames !== 8'd2 || ss_n_o !== 1'b1) && i < 300) begin
            @(posedge clk_i);
            i++;
        end
        repeat (4) @(posedge clk_i);
        check("sck enable", sck_oe_o, 1);
        check("mosi enable", mosi_oe_o, 1);
        check("select enable", ss_n_oe_o, 1);
        rdchk(OFF_CTRL1, 32'h12, "ctrl1 readback");
        rdchk(OFF_BUFFER, 32'h3c, "data unarmed");
        rdchk(OFF_FLAGS, 32'ha0, "flags kept");
        rdchk(OFF_BUFFER, 32'h3c, "data old byte");
        rdchk(OFF_FLAGS, 32'h20, "flags cleared");
        check("peer frames", peer_frames, 2);
        check("peer second byte", peer_last, 8'h69);
        $display("test transfer done");
        // fault detection only in the one configuration
        for (i = 0; i < 3; i++) begin
            wr(OFF_CTRL2, {24'h0, c2_tab[i]});
            wr(OFF_CTRL1, {24'h0, c1_tab[i]});
            ss_drv <= 1'b0;
            repeat (6) @(posedge clk_i);
            ss_drv <= 1'b1;
            repeat (4) @(posedge clk_i);
            rdchk(OFF_FLAGS, {24'h0, 8'h20 | flt_tab[i]}, "mode fault");
        end
        check("rx irq on", rx_irq_o, 1);
        apb(1'b0, OFF_CTRL2, 32'h0);
        wr(OFF_CTRL1, 32'h90);
        rdchk(OFF_FLAGS, 32'h30, "fault unarmed");
        wr(OFF_CTRL1, 32'hb0);
        rdchk(OFF_FLAGS, 32'h20, "fault cleared");
        check("rx irq off", rx_irq_o, 0);
        check("tx irq on", tx_irq_o, 1);
        $display("test mode fault done");
        // slave byte clocked in by the bench, mode 0, 800 ns link clock
        wr(OFF_CTRL1, 32'h80);
        ss_drv <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("slave miso enable", miso_oe_o, 1);
        for (i = 7; i >= 0; i--) begin
            mosi_drv <= SL_BYTE[i];
            repeat (4) @(posedge clk_i);
            sck_drv <= 1'b1;
            repeat (4) @(posedge clk_i);
            sck_drv <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        ss_drv <= 1'b1;
        rdchk(OFF_FLAGS, 32'ha0, "slave flags");
        rdchk(OFF_BUFFER, {24'h0, SL_BYTE}, "slave byte");
        rdchk(OFF_FLAGS, 32'h20, "slave cleared");
        $display("test slave receive done");
        complete_run();
    end
endmodule // tb_spi_status_data_buffering
